// ### design/crtvt_pkg.sv
// Constants of the vertical timing register block: indices, fields, widths.
// Assumes a host port that presents an index and an 8-bit data byte per access.
// Behaviour
// - Index register selects register, data port accesses
// - Lock bit blocks writes to indices 0-7
// - Line compare bit of overflow stays writable
// - Bit 6 selects five or three refreshes
// - Bit 5 zero enables vertical interrupt
// - Display end sets interrupt flip-flop
// - Writing zero to bit 4 clears flip-flop
// - Retrace end register reads back stored value
// - Retrace ends when counter low nibble matches
// - Display end built from two registers
// - Active video ends at display end line
// - Row start advances two or four times offset
// - Doubleword bit selects doubleword addressing
// - Count-by-four divides address clock by four
// - Underline row field, one less than wanted
// - Blank start built from three registers
// - Blanking starts at blank start plus one
// - Blanking ends when low byte matches end
// - Retrace start from index 0x10 and overflow
package crtvt_pkg;
  localparam int CRTVT_IDX_W = 5;
  localparam int CRTVT_LINE_W = 10;
  localparam logic [4:0] CRTVT_IDX_PROT_HI = 5'h07;
  localparam logic [4:0] CRTVT_IDX_OVERFLOW = 5'h07;
  localparam logic [4:0] CRTVT_IDX_MAXSCAN = 5'h09;
  localparam logic [4:0] CRTVT_IDX_RETR_START = 5'h10;
  localparam logic [4:0] CRTVT_IDX_RETR_END = 5'h11;
  localparam logic [4:0] CRTVT_IDX_DISP_END = 5'h12;
  localparam logic [4:0] CRTVT_IDX_ROW_OFFSET = 5'h13;
  localparam logic [4:0] CRTVT_IDX_UNDERLINE = 5'h14;
  localparam logic [4:0] CRTVT_IDX_BLANK_START = 5'h15;
  localparam logic [4:0] CRTVT_IDX_BLANK_END = 5'h16;
  // Retrace end control fields
  localparam int CRTVT_LOCK_BIT = 7;
  localparam int CRTVT_REFRESH5_BIT = 6;
  localparam int CRTVT_IRQ_DIS_BIT = 5;
  localparam int CRTVT_IRQ_CLRN_BIT = 4;
  // Overflow and maximum scan fields used here
  localparam int CRTVT_OV_RETR8 = 7;
  localparam int CRTVT_OV_DISP9 = 6;
  localparam int CRTVT_OV_LCMP8 = 4;
  localparam int CRTVT_OV_BLANK8 = 3;
  localparam int CRTVT_OV_DISP8 = 1;
  localparam int CRTVT_MS_BLANK9 = 5;
  // Underline control fields
  localparam int CRTVT_DWORD_BIT = 6;
  localparam int CRTVT_CNT4_BIT = 5;
  localparam logic [7:0] CRTVT_UL_MASK = 8'h7F;
  localparam logic [7:0] CRTVT_OV_LCMP_MASK = 8'h10;
  localparam logic [7:0] CRTVT_REG_RESET = 8'h00;
  localparam logic [7:0] CRTVT_RETR_END_RESET = 8'h10;
  localparam logic [2:0] CRTVT_REFRESH_FIVE = 3'h5;
  localparam logic [2:0] CRTVT_REFRESH_THREE = 3'h3;
  localparam logic [1:0] CRTVT_DIV4_LAST = 2'h3;
endpackage

// ### design/crtvt_line_cmp.sv
// Compares the vertical line counter against the programmed limits.
// Assumes all inputs are on the reference clock; purely combinational.
module crtvt_line_cmp
  import crtvt_pkg::*;
(
  input wire logic [9:0] line_i,
  input wire logic [9:0] disp_end_i,
  input wire logic [9:0] blank_start_i,
  input wire logic [7:0] blank_end_i,
  input wire logic [9:0] retr_start_i,
  input wire logic [3:0] retr_end_i,
  output logic disp_end_hit_o,
  output logic blank_on_hit_o,
  output logic blank_off_hit_o,
  output logic retr_on_hit_o,
  output logic retr_off_hit_o
);
  always_comb
  begin
    disp_end_hit_o = (line_i == disp_end_i);
    blank_on_hit_o = (line_i == blank_start_i + 10'h001);
    blank_off_hit_o = (line_i[7:0] == blank_end_i);
    retr_on_hit_o = (line_i == retr_start_i);
    retr_off_hit_o = (line_i[3:0] == retr_end_i);
  end
endmodule

// ### design/crtvt_regs.sv
// Vertical timing registers 0x11-0x16 with line counter and interrupt flop.
// Rows and characters are counted outside; vertical limits, row offset and underline control live here.
// Assumes host accesses arrive as one-cycle strobes on ref_clk_i with an index
// already latched by the address register; line and char clock ticks are
// one-cycle enables from the horizontal logic on the same clock.
module crtvt_regs
  import crtvt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] host_index_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic host_rd_hit_o,
  output logic low_wr_allow_o,
  output logic [7:0] overflow_o,
  output logic [7:0] max_scan_o,
  output logic [7:0] retr_start_o,
  input wire logic line_tick_i,
  input wire logic frame_start_i,
  input wire logic char_tick_i,
  output logic [9:0] line_count_o,
  output logic vdisp_en_o,
  output logic vblank_o,
  output logic vretrace_o,
  output logic host_irq_line_o,
  output logic irq_pending_o,
  output logic [2:0] refresh_cycles_o,
  output logic dword_mode_o,
  output logic addr_clk_en_o,
  output logic [9:0] row_step_o,
  output logic [4:0] underline_row_o
);
  logic [7:0] vertical_retrace_end_ctl_r;
  logic [7:0] display_enable_end_low_r;
  logic [7:0] row_offset_r;
  logic [7:0] underline_row_ctl_r;
  logic [7:0] blank_start_low_r;
  logic [7:0] blank_end_r;
  logic [7:0] overflow_r;
  logic [7:0] max_scan_r;
  logic [7:0] retr_start_r;
  logic [9:0] line_r;
  logic vdisp_r;
  logic vblank_r;
  logic vretrace_r;
  logic irq_ff_r;
  logic [1:0] div4_r;
  logic [7:0] rdata_r;
  logic rd_hit_r;
  logic [9:0] disp_end;
  logic [9:0] blank_start;
  logic [9:0] retr_start;
  logic disp_end_hit;
  logic blank_on_hit;
  logic blank_off_hit;
  logic retr_on_hit;
  logic retr_off_hit;
  logic low_lock;
  logic irq_clear;
  logic irq_ack_wr;
  logic irq_set;

  // Index decode used by the write paths; the read path decodes with a case
  function automatic logic idx_is(input logic [4:0] idx, input logic [4:0] sel);
    idx_is = (idx == sel);
  endfunction

  // Range of this block's indices, used by the read hit
  function automatic logic idx_in_block(input logic [4:0] idx);
    idx_in_block = (idx >= CRTVT_IDX_RETR_END) && (idx <= CRTVT_IDX_BLANK_END);
  endfunction

  assign low_lock = vertical_retrace_end_ctl_r[CRTVT_LOCK_BIT];
  // Outside indices 0-7 are owned elsewhere; this tells them whether to accept
  assign low_wr_allow_o = ~low_lock;

  // Protected low registers held here: overflow only, since it feeds our limits
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      overflow_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_OVERFLOW))
    begin
      if (!low_lock)
        overflow_r <= host_wdata_i;
      else
        overflow_r <= (overflow_r & ~CRTVT_OV_LCMP_MASK) | (host_wdata_i & CRTVT_OV_LCMP_MASK);
    end
  end

  // Write-only copies of limit bits owned by outside registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      max_scan_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_MAXSCAN))
      max_scan_r <= host_wdata_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      retr_start_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_RETR_START))
      retr_start_r <= host_wdata_i;
  end

  // Registers of this block, one process each; none of them is write protected
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      vertical_retrace_end_ctl_r <= CRTVT_RETR_END_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_RETR_END))
      vertical_retrace_end_ctl_r <= host_wdata_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      display_enable_end_low_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_DISP_END))
      display_enable_end_low_r <= host_wdata_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      row_offset_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_ROW_OFFSET))
      row_offset_r <= host_wdata_i;
  end

  // Reserved bit 7 is not stored so it reads as zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      underline_row_ctl_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_UNDERLINE))
      underline_row_ctl_r <= host_wdata_i & CRTVT_UL_MASK;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      blank_start_low_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_BLANK_START))
      blank_start_low_r <= host_wdata_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      blank_end_r <= CRTVT_REG_RESET;
    else if (host_wr_i && idx_is(host_index_i, CRTVT_IDX_BLANK_END))
      blank_end_r <= host_wdata_i;
  end

  // Hit pulse lasts one cycle; the data below holds until the next read
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      rd_hit_r <= 1'b0;
    else
      rd_hit_r <= host_rd_i && idx_in_block(host_index_i);
  end

  // Read path; registered data, valid one cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      rdata_r <= CRTVT_REG_RESET;
    else if (host_rd_i)
    begin
      unique case (host_index_i)
        CRTVT_IDX_RETR_END: rdata_r <= vertical_retrace_end_ctl_r;
        CRTVT_IDX_DISP_END: rdata_r <= display_enable_end_low_r;
        CRTVT_IDX_ROW_OFFSET: rdata_r <= row_offset_r;
        CRTVT_IDX_UNDERLINE: rdata_r <= underline_row_ctl_r;
        CRTVT_IDX_BLANK_START: rdata_r <= blank_start_low_r;
        CRTVT_IDX_BLANK_END: rdata_r <= blank_end_r;
        // Indices owned elsewhere read as zero here
        default: rdata_r <= CRTVT_REG_RESET;
      endcase
    end
  end

  // Assemble 10-bit limits
  always_comb
  begin
    disp_end = {overflow_r[CRTVT_OV_DISP9], overflow_r[CRTVT_OV_DISP8],
      display_enable_end_low_r};
    blank_start = {max_scan_r[CRTVT_MS_BLANK9], overflow_r[CRTVT_OV_BLANK8],
      blank_start_low_r};
    retr_start = {1'b0, overflow_r[CRTVT_OV_RETR8], retr_start_r};
  end

  // Compares are combinational; the flag processes sample them on the tick
  crtvt_line_cmp u_cmp (
    .line_i(line_r),
    .disp_end_i(disp_end),
    .blank_start_i(blank_start),
    .blank_end_i(blank_end_r),
    .retr_start_i(retr_start),
    .retr_end_i(vertical_retrace_end_ctl_r[3:0]),
    .disp_end_hit_o(disp_end_hit),
    .blank_on_hit_o(blank_on_hit),
    .blank_off_hit_o(blank_off_hit),
    .retr_on_hit_o(retr_on_hit),
    .retr_off_hit_o(retr_off_hit)
  );

  // Line counter, cleared by frame start from the vertical total logic
  // Wraps at 1024 lines if no frame start comes, so compares stay defined
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      line_r <= '0;
    else if (frame_start_i)
      line_r <= '0;
    else if (line_tick_i)
      line_r <= line_r + 10'h001;
  end

  // Timing flags update only on line ticks or frame start so compares act once per line
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      vdisp_r <= 1'b1;
    else if (frame_start_i)
      vdisp_r <= 1'b1;
    else if (line_tick_i && disp_end_hit)
      vdisp_r <= 1'b0;
  end

  // Off wins over on, so a blank whose end equals its start plus one stays low
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      vblank_r <= 1'b0;
    else if (line_tick_i && !frame_start_i)
    begin
      if (blank_off_hit)
        vblank_r <= 1'b0;
      else if (blank_on_hit)
        vblank_r <= 1'b1;
    end
  end

  // Retrace follows the same priority as blanking
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      vretrace_r <= 1'b0;
    else if (line_tick_i && !frame_start_i)
    begin
      if (retr_off_hit)
        vretrace_r <= 1'b0;
      else if (retr_on_hit)
        vretrace_r <= 1'b1;
    end
  end

  // Interrupt flop: set at end of active display; bit 4 low holds it clear.
  // A write of zero clears at once, so the acknowledge is not a cycle late.
  assign irq_ack_wr = host_wr_i && idx_is(host_index_i, CRTVT_IDX_RETR_END)
    && !host_wdata_i[CRTVT_IRQ_CLRN_BIT];
  assign irq_clear = ~vertical_retrace_end_ctl_r[CRTVT_IRQ_CLRN_BIT] | irq_ack_wr;
  assign irq_set = line_tick_i && disp_end_hit && vdisp_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      irq_ff_r <= 1'b0;
    else if (irq_clear)
      irq_ff_r <= 1'b0;
    else if (irq_set)
      irq_ff_r <= 1'b1;
  end

  // Masking leaves the flop alone, so status still shows a masked event
  always_comb
  begin
    if (vertical_retrace_end_ctl_r[CRTVT_IRQ_DIS_BIT])
      host_irq_line_o = 1'b0;
    else
      host_irq_line_o = irq_ff_r;
  end
  // Status source for the input status register outside
  assign irq_pending_o = irq_ff_r;

  // Address clock divider for count-by-four
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      div4_r <= '0;
    else if (char_tick_i)
      div4_r <= div4_r + 2'h1;
  end

  // Count-by-four gates the char tick; the divider runs free, so its phase is arbitrary
  always_comb
  begin
    if (underline_row_ctl_r[CRTVT_CNT4_BIT])
      addr_clk_en_o = char_tick_i && (div4_r == CRTVT_DIV4_LAST);
    else
      addr_clk_en_o = char_tick_i;
  end

  assign dword_mode_o = underline_row_ctl_r[CRTVT_DWORD_BIT];
  // Underline row passes as written; the row scan logic adds the one
  assign underline_row_o = underline_row_ctl_r[4:0];

  // Step in address units: offset times two, or four in doubleword mode
  always_comb
  begin
    if (dword_mode_o)
      row_step_o = {row_offset_r, 2'b00};
    else
      row_step_o = {1'b0, row_offset_r, 1'b0};
  end

  always_comb
  begin
    if (vertical_retrace_end_ctl_r[CRTVT_REFRESH5_BIT])
      refresh_cycles_o = CRTVT_REFRESH_FIVE;
    else
      refresh_cycles_o = CRTVT_REFRESH_THREE;
  end

  // Registered state straight to the ports
  assign host_rdata_o = rdata_r;
  assign host_rd_hit_o = rd_hit_r;
  assign overflow_o = overflow_r;
  assign max_scan_o = max_scan_r;
  assign retr_start_o = retr_start_r;
  assign line_count_o = line_r;
  assign vdisp_en_o = vdisp_r;
  assign vblank_o = vblank_r;
  assign vretrace_o = vretrace_r;
endmodule

// ### sim/crtvt_regs_checker.sv
// Port checker for the vertical timing register block.
// Assumes one clock, synchronous active-low reset and a write shadow kept here.
module crtvt_regs_checker (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] host_index_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_rd_hit_o,
  input wire logic low_wr_allow_o,
  input wire logic [7:0] overflow_o,
  input wire logic [7:0] max_scan_o,
  input wire logic line_tick_i,
  input wire logic frame_start_i,
  input wire logic [9:0] line_count_o,
  input wire logic vdisp_en_o,
  input wire logic vblank_o,
  input wire logic vretrace_o,
  input wire logic host_irq_line_o,
  input wire logic irq_pending_o,
  input wire logic [2:0] refresh_cycles_o
);
  logic [7:0] sh [0:31];
  logic [7:0] r11;
  logic lt_ok;
  assign r11 = sh[17];
  assign lt_ok = line_tick_i && !frame_start_i && !host_wr_i;
  // Shadow ignores the lock; only indices above 7 are read from it
  always_ff @(posedge ref_clk_i)
  begin
    for (int k = 0; k < 32; k++)
      sh[k] <= (!resetn_i) ? ((k == 17) ? 8'h10 : 8'h00)
             : (host_wr_i && host_index_i == 5'(k)) ? host_wdata_i : sh[k];
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_ack;
    host_wr_i && host_index_i == 5'h11 && !host_wdata_i[4];
  endsequence
  sequence s_disp_end;
    lt_ok && vdisp_en_o && r11[4] && line_count_o == {overflow_o[6], overflow_o[1], sh[18]};
  endsequence
  a_irq_clear: assert property (s_ack |=> !irq_pending_o) else $error("irq not cleared");
  a_irq_set: assert property (s_disp_end |=> irq_pending_o && !vdisp_en_o)
    else $error("display end missed");
  a_irq_line: assert property (host_irq_line_o == (irq_pending_o && !r11[5]))
    else $error("irq line wrong");
  a_refresh_sel: assert property (refresh_cycles_o == (r11[6] ? 3'h5 : 3'h3))
    else $error("refresh count wrong");
  a_lock_out: assert property (low_wr_allow_o == !r11[7]) else $error("lock wrong");
  a_lock_ovf: assert property (host_wr_i && host_index_i == 5'h07 && !low_wr_allow_o |=>
    overflow_o == (($past(overflow_o) & 8'hEF) | ($past(host_wdata_i) & 8'h10)))
    else $error("overflow lock wrong");
  a_read_back: assert property (host_rd_i && host_index_i == 5'h11 |=>
    host_rd_hit_o && host_rdata_o == $past(r11)) else $error("readback wrong");
  a_retr_off: assert property (lt_ok && line_count_o[3:0] == r11[3:0] |=> !vretrace_o)
    else $error("retrace end missed");
  a_blank_off: assert property (lt_ok && line_count_o[7:0] == sh[22] |=> !vblank_o)
    else $error("blank end missed");
  a_blank_on: assert property (lt_ok && line_count_o[7:0] != sh[22] &&
    line_count_o == {max_scan_o[5], overflow_o[3], sh[21]} + 10'h1 |=> vblank_o)
    else $error("blank start missed");
  a_line_step: assert property (line_tick_i && !frame_start_i |=>
    line_count_o == $past(line_count_o) + 10'h1) else $error("line step wrong");
endmodule
bind crtvt_regs crtvt_regs_checker u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .host_index_i(host_index_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rd_hit_o(host_rd_hit_o),
  .low_wr_allow_o(low_wr_allow_o), .overflow_o(overflow_o), .max_scan_o(max_scan_o),
  .line_tick_i(line_tick_i), .frame_start_i(frame_start_i), .line_count_o(line_count_o),
  .vdisp_en_o(vdisp_en_o), .vblank_o(vblank_o), .vretrace_o(vretrace_o),
  .host_irq_line_o(host_irq_line_o), .irq_pending_o(irq_pending_o),
  .refresh_cycles_o(refresh_cycles_o));

// ### sim/crtvt_host.sv
// Host processor model: index register plus one-cycle data port strobes.
// Assumes the bench calls put just after a falling clock edge.
module crtvt_host (
  output logic [4:0] host_index_o,
  output logic host_wr_o,
  output logic host_rd_o,
  output logic [7:0] host_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_index_o = 5'h00;
  initial host_wr_o = 1'b0;
  initial host_rd_o = 1'b0;
  initial host_wdata_o = 8'h00;
  task automatic put(input bit w, r, input logic [4:0] i, input logic [7:0] d);
    host_index_o = i;
    host_wr_o = w;
    host_rd_o = r;
    host_wdata_o = w ? d : ~host_wdata_o; // Released bus must not show a stale byte
  endtask
endmodule

// ### sim/crtvt_regs_tb.sv
// Bench for the vertical timing registers, with a line and register model.
// Assumes the host model on the data port and bench-driven line ticks.
module crtvt_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, lt = 0, fs = 0, ct = 0, ctf = 0;
  wire [4:0] idx, ul;
  wire wr, rd, rhit, alw, vd, vb, vr, irql, irqp, dw, ace;
  wire [7:0] wd, rdata, ovf, msc, rsv;
  wire [9:0] lc, rstep;
  wire [2:0] rf;
  int m [32];
  int line, mvd = 1, mvb, mvr, mirq, mrd, mhit, nace, num_errors, n_checks;
  logic [31:0] seed = 32'h4D9FCA11;
  crtvt_host host (.host_index_o(idx), .host_wr_o(wr), .host_rd_o(rd), .host_wdata_o(wd));
  crtvt_regs DUT (.ref_clk_i(clk), .resetn_i(rstn), .host_index_i(idx), .host_wr_i(wr),
    .host_rd_i(rd), .host_wdata_i(wd), .host_rdata_o(rdata), .host_rd_hit_o(rhit),
    .low_wr_allow_o(alw), .overflow_o(ovf), .max_scan_o(msc), .retr_start_o(rsv),
    .line_tick_i(lt), .frame_start_i(fs), .char_tick_i(ct), .line_count_o(lc),
    .vdisp_en_o(vd), .vblank_o(vb), .vretrace_o(vr), .host_irq_line_o(irql),
    .irq_pending_o(irqp), .refresh_cycles_o(rf), .dword_mode_o(dw), .addr_clk_en_o(ace),
    .row_step_o(rstep), .underline_row_o(ul));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One host cycle with line stimulus; the model steps on the same edge
  task automatic cyc(input bit w, r, input int i, d, input bit t, f);
    int de, bs, ln;
    @(negedge clk);
    host.put(w, r, 5'(i), 8'(d));
    lt = t;
    fs = f;
    ct = ctf | 1'(rnd());
    #1 nace += ace;
    @(posedge clk);
    ln = line;
    de = {m[7][6], m[7][1], m[18][7:0]};
    bs = {m[9][5], m[7][3], m[21][7:0]};
    if (f)
    begin
      line = 0;
      mvd = 1;
    end
    else if (t)
    begin
      if (ln == de && mvd && m[17][4]) mirq = 1;
      if (ln == de) mvd = 0;
      if (ln % 256 == m[22]) mvb = 0;
      else if (ln == bs + 1) mvb = 1;
      if (ln % 16 == m[17] % 16) mvr = 0;
      else if (ln == {m[7][7], m[16][7:0]}) mvr = 1;
      line = (ln + 1) % 1024;
    end
    mhit = r && i >= 17 && i <= 22;
    if (r) mrd = mhit ? ((i == 20) ? m[i] % 128 : m[i]) : 0;
    if (w && !(i < 8 && m[17][7])) m[i] = d % 256;
    else if (w && i == 7) m[7] = (m[7] & 8'hEF) | (d & 8'h10);
    if (!m[17][4]) mirq = 0;
    #1;
    chk("line", lc, line);
    chk("vdisp", vd, mvd);
    chk("vblank", vb, mvb);
    chk("vretrace", vr, mvr);
    chk("irq_pending", irqp, mirq);
    chk("irq_line", irql, m[17][5] ? 0 : mirq);
    chk("rdata", rdata, mrd);
    chk("rd_hit", rhit, mhit);
    chk("allow", alw, !m[17][7]);
    chk("refresh", rf, m[17][6] ? 5 : 3);
    chk("overflow", ovf, m[7]);
    chk("max_scan", msc, m[9]);
    chk("retr_start", rsv, m[16]);
    chk("dword", dw, m[20][6]);
    chk("row_step", rstep, m[19] * (m[20][6] ? 4 : 2));
    chk("underline", ul, m[20] % 32);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial
  begin
    int pi [8] = '{7, 9, 16, 17, 18, 20, 21, 22};
    int pv [8];
    m[17] = 16;
    repeat (16) @(posedge clk);
    @(negedge clk) rstn = 1;
    cyc(0, 0, 0, 0, 0, 0);
    for (int k = 5; k < 25; k++)
    begin
      cyc(1, 0, k, rnd() & 32'h7F, 0, 0);
      cyc(0, 1, k, 0, 0, 0);
    end
    cyc(1, 0, 17, 8'h9D, 0, 0);
    cyc(1, 0, 7, rnd(), 0, 0);
    cyc(1, 1, 17, 8'h1D, 0, 0);
    cyc(1, 0, 7, 8'h00, 0, 0);
    for (int f = 0; f < 2; f++)
    begin
      // Second frame uses bit 8 of every limit and keeps the interrupt masked
      pv = '{f ? 8'h8A : 0, 0, 27, f ? 8'h3D : 8'h1D, 20, f ? 8'h40 : 0, 24, 30};
      foreach (pi[j]) cyc(1, 0, pi[j], pv[j], 0, 0);
      cyc(0, 0, 0, 0, 0, 1);
      for (int n = 0; n < 300; n++)
      begin
        cyc(0, 0, 0, 0, 1, 0);
        cyc(0, n % 7 == 0, 17, 0, 0, 0);
      end
      cyc(0, 1, 17, 0, 0, 0);
      cyc(1, 0, 17, m[17] & 8'hEF, 0, 0);
      cyc(1, 0, 17, m[17] | 8'h10, 0, 0);
    end
    cyc(1, 0, 20, 8'h60, 0, 0);
    ctf = 1;
    nace = 0;
    repeat (16) cyc(0, 0, 0, 0, 0, 0);
    chk("addr_clk", 10'(nace), 10'h4);
    summarize();
  end
endmodule
